//--- hdl/kbd_scan_pkg.sv
// constants, register map and state type of the key matrix scanner
// assumes a 200 MHz system clock and an AXI4-Lite register master
//
// Behaviour
// - idle holds all columns high, awaits row change
// - row change in idle requests clock, starts scan
// - idle clears row-hit and key-index to zero
// - row counter steps zero to rows minus one
// - after last row: row zero, column advances
// - both counters terminal: move to scan-end
// - key index counts; modifiers matched, others buffered
// - buffered value is the raw key index
// - two or more column hits: OR into row-hit
// - hit on earlier-column row-hit row sets ghost
// - scan-end with keys seen starts another pass
// - scan-end without keys: idle, drop clock request
// - column count programmable one to twenty
// - row count programmable one to eight
// - sixteen byte hardware key-code buffer
// - codes kept until read; on overflow new codes are dropped
// - any key count; ghosting key locked out
// - row inputs filtered against glitches and bounce
// - full matrix pass about 1.25 ms at 128 kHz
package kbd_scan_pkg;

  // clocking of the scan steps
  localparam int unsigned SYS_CLK_HZ   = 200_000_000;
  localparam int unsigned SCAN_CLK_HZ  = 128_000;
  localparam int unsigned TICK_CYCLES  = SYS_CLK_HZ / SCAN_CLK_HZ;
  localparam int          TICK_W       = 11;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // matrix and buffer geometry
  localparam int NUM_ROWS   = 8;
  localparam int NUM_COLS   = 20;
  localparam int ROWS_W     = 4;
  localparam int COLS_W     = 5;
  localparam int ROW_IDX_W  = 3;
  localparam int CODE_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int LEVEL_W    = 5;
  localparam int NUM_MODS   = 4;
  localparam int FILT_LEN   = 4;
  localparam logic [LEVEL_W-1:0] FIFO_FULL_LVL = 5'h10;

  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_KEYDATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MODCODE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MODSTAT = 8'h10;

  // control fields and reset values
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_ROWS_LSB = 8;
  localparam int CTRL_COLS_LSB = 16;
  localparam logic [ROWS_W-1:0] ROWS_MAX = 4'h8;
  localparam logic [COLS_W-1:0] COLS_MAX = 5'h14;
  localparam logic [CODE_W-1:0] MOD_CODE_RST = 8'hFF;

  // status and key data fields
  localparam int STB_GHOST     = 0;
  localparam int STB_OVF       = 1;
  localparam int STB_KEY       = 2;
  localparam int STB_EMPTY     = 3;
  localparam int STB_FULL      = 4;
  localparam int STB_BUSY      = 5;
  localparam int STB_LEVEL_LSB = 8;
  localparam int KEY_VALID_BIT = 8;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // scanner sequence
  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_SCAN_END} scan_st_t;

endpackage : kbd_scan_pkg

//--- hdl/row_filter.sv
// glitch and bounce filter for the row inputs
// assumes row inputs synchronous to sys_clk
`timescale 1ns/1ps
module row_filter (
  input  wire logic                              sys_clk,
  input  wire logic                              rstn,
  input  wire logic [kbd_scan_pkg::NUM_ROWS-1:0] rows_raw,
  output logic      [kbd_scan_pkg::NUM_ROWS-1:0] rows_clean
);
  import kbd_scan_pkg::*;

  logic [NUM_ROWS-1:0] hist_r [FILT_LEN];  // sample history
  logic [NUM_ROWS-1:0] clean_r;            // filtered level
  logic [NUM_ROWS-1:0] all_hi;             // every sample high
  logic [NUM_ROWS-1:0] all_lo;             // every sample low

  // a row changes only after FILT_LEN equal samples
  always_comb begin
    all_hi = {NUM_ROWS{1'b1}};
    all_lo = {NUM_ROWS{1'b1}};
    for (int i = 0; i < FILT_LEN; i++) begin
      all_hi = all_hi & hist_r[i];
      all_lo = all_lo & ~hist_r[i];
    end
  end

  // shift history, hold output while samples disagree
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < FILT_LEN; i++) hist_r[i] <= '0;
      clean_r <= '0;
    end else begin
      hist_r[0] <= rows_raw;
      for (int i = 1; i < FILT_LEN; i++) hist_r[i] <= hist_r[i-1];
      clean_r <= all_hi | (clean_r & ~all_lo);
    end
  end

  assign rows_clean = clean_r;

endmodule : row_filter

//--- hdl/keyboard_matrix_scanner.sv
// key matrix scanner with AXI4-Lite register slave
// assumes rows pulled low, a pressed key links a driven-high column
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module keyboard_matrix_scanner (
  input  wire logic                              sys_clk,
  input  wire logic                              rstn,
  input  wire logic [kbd_scan_pkg::NUM_ROWS-1:0] row_in,
  output logic      [kbd_scan_pkg::NUM_COLS-1:0] col_out,
  output logic                                   scan_clk_req,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [kbd_scan_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  input  wire logic [kbd_scan_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [kbd_scan_pkg::STRB_W-1:0]   s_axi_wstrb,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  output logic      [1:0]                        s_axi_bresp,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  input  wire logic [kbd_scan_pkg::ADDR_W-1:0]   s_axi_araddr,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  output logic      [kbd_scan_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]                        s_axi_rresp
);
  import kbd_scan_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // mask of the active rows for a row count of 1..8
  function automatic logic [NUM_ROWS-1:0] row_mask(
    input logic [ROWS_W-1:0] n);
    logic [NUM_ROWS:0] one;
    one = {{NUM_ROWS{1'b0}}, 1'b1};
    row_mask = NUM_ROWS'((one << n) - one);
  endfunction : row_mask

  // true when two or more bits are set
  function automatic logic multi_hit(input logic [NUM_ROWS-1:0] v);
    multi_hit = (v & (v - NUM_ROWS'(1))) != '0;
  endfunction : multi_hit

  // keep a count in 1..hi
  function automatic logic [COLS_W-1:0] clamp(
    input logic [COLS_W-1:0] v, input logic [COLS_W-1:0] hi);
    if (v == '0) clamp = COLS_W'(1);
    else if (v > hi) clamp = hi;
    else clamp = v;
  endfunction : clamp

  // drive pattern selecting a single column
  function automatic logic [NUM_COLS-1:0] col_sel(
    input logic [COLS_W-1:0] c);
    col_sel = {{(NUM_COLS-1){1'b0}}, 1'b1} << c;
  endfunction : col_sel

  // which modifier codes equal the current key index
  function automatic logic [NUM_MODS-1:0] mod_hits(
    input logic [CODE_W*NUM_MODS-1:0] codes,
    input logic [CODE_W-1:0] idx);
    mod_hits = '0;
    for (int i = 0; i < NUM_MODS; i++)
      mod_hits[i] = codes[i*CODE_W +: CODE_W] == idx;
  endfunction : mod_hits

  // byte lane merge for partial writes
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] nw,
    input logic [STRB_W-1:0] strb);
    merge = old;
    for (int i = 0; i < STRB_W; i++)
      if (strb[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // state and storage

  logic                       en_r;         // scanner enable
  logic [ROWS_W-1:0]          rows_cfg_r;   // active rows, 1..8
  logic [COLS_W-1:0]          cols_cfg_r;   // active columns, 1..20
  logic [CODE_W*NUM_MODS-1:0] mod_codes_r;  // modifier key indices
  logic [NUM_MODS-1:0]        mod_stat_r;   // modifiers held last pass
  logic [NUM_MODS-1:0]        mod_pass_r;   // modifiers seen this pass
  scan_st_t                   state_r;      // sequence state
  logic [ROW_IDX_W-1:0]       row_r;        // row counter
  logic [COLS_W-1:0]          col_r;        // column counter
  logic [CODE_W-1:0]          key_idx_r;    // key index counter
  logic [NUM_ROWS-1:0]        row_hit_r;    // multi-hit row history
  logic                       key_pass_r;   // any key in this pass
  logic                       clk_req_r;    // scan clock request
  logic [NUM_COLS-1:0]        col_drv_r;    // column drive pattern
  logic [TICK_W-1:0]          tick_cnt_r;   // scan step divider
  logic [NUM_ROWS-1:0]        rows_prev_r;  // filtered rows, one back
  logic                       ghost_r;      // ghost seen
  logic                       ovf_r;        // buffer overflowed
  logic                       key_seen_r;   // key seen since read
  logic [CODE_W-1:0]          fifo_r [FIFO_DEPTH]; // key code buffer
  logic [FIFO_AW-1:0]         wp_r;         // buffer write pointer
  logic [FIFO_AW-1:0]         rp_r;         // buffer read pointer
  logic [LEVEL_W-1:0]         lvl_r;        // buffer fill level
  logic [NUM_ROWS-1:0]        rows_f;       // filtered row inputs

  // bus side
  logic              awready_r, wready_r, bvalid_r;
  logic              arready_r, rvalid_r;
  logic              aw_hold_r, w_hold_r;   // write halves captured
  logic [ADDR_W-1:0] waddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [STRB_W-1:0] wstrb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [DATA_W-1:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // row input filter

  row_filter u_row_filter (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .rows_raw   (row_in),
    .rows_clean (rows_f)
  );

  ////////////////////////////////////////////////////////////////////////////
  // scan decode

  wire [NUM_ROWS-1:0] rows_act = rows_f & row_mask(rows_cfg_r);
  wire tick     = clk_req_r && (tick_cnt_r == TICK_LAST);
  wire step     = (state_r == S_SCAN) && tick;
  wire cur_key  = rows_act[row_r];
  wire ghost_hit = cur_key && row_hit_r[row_r];
  wire [NUM_MODS-1:0] mods = mod_hits(mod_codes_r, key_idx_r);
  wire is_mod   = |mods;
  wire last_row = row_r == ROW_IDX_W'(rows_cfg_r - ROWS_W'(1));
  wire last_col = col_r == (cols_cfg_r - COLS_W'(1));
  wire wake     = en_r && (rows_f != rows_prev_r);
  wire fifo_full  = lvl_r == FIFO_FULL_LVL;
  wire fifo_empty = lvl_r == '0;
  // ghosting key is locked out of the buffer
  wire push     = step && cur_key && !ghost_hit && !is_mod;
  wire push_ok  = push && !fifo_full;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire aw_hs  = s_axi_awvalid && awready_r;
  wire w_hs   = s_axi_wvalid && wready_r;
  wire wr_do  = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_ctrl = wr_do && (waddr_r == OFF_CTRL);
  wire wr_mod  = wr_do && (waddr_r == OFF_MODCODE);
  wire aw_hold_nxt = (aw_hold_r || aw_hs) && !wr_do;
  wire w_hold_nxt  = (w_hold_r || w_hs) && !wr_do;
  wire bvalid_nxt  = wr_do || (bvalid_r && !s_axi_bready);
  wire ar_hs  = s_axi_arvalid && arready_r;
  wire rvalid_nxt  = ar_hs || (rvalid_r && !s_axi_rready);
  wire rd_stat = ar_hs && (s_axi_araddr == OFF_STATUS);
  wire rd_key  = ar_hs && (s_axi_araddr == OFF_KEYDATA);
  wire pop     = rd_key && !fifo_empty;

  wire [DATA_W-1:0] ctrl_word =
    (DATA_W'(cols_cfg_r) << CTRL_COLS_LSB) |
    (DATA_W'(rows_cfg_r) << CTRL_ROWS_LSB) |
    (DATA_W'(en_r) << CTRL_EN_BIT);
  wire [DATA_W-1:0] ctrl_new = merge(ctrl_word, wdata_r, wstrb_r);
  wire [DATA_W-1:0] mod_new  = merge(mod_codes_r, wdata_r, wstrb_r);
  // status word, polled by software
  wire [DATA_W-1:0] stat_word =
    (DATA_W'(lvl_r) << STB_LEVEL_LSB) |
    (DATA_W'(state_r != S_IDLE) << STB_BUSY) |
    (DATA_W'(fifo_full) << STB_FULL) |
    (DATA_W'(fifo_empty) << STB_EMPTY) |
    (DATA_W'(key_seen_r) << STB_KEY) |
    (DATA_W'(ovf_r) << STB_OVF) |
    (DATA_W'(ghost_r) << STB_GHOST);
  wire [DATA_W-1:0] key_word =
    (DATA_W'(!fifo_empty) << KEY_VALID_BIT) | DATA_W'(fifo_r[rp_r]);
  wire rd_stat_a = s_axi_araddr == OFF_STATUS;
  wire mapped_rd = (s_axi_araddr == OFF_CTRL) || rd_stat_a ||
                   (s_axi_araddr == OFF_KEYDATA) ||
                   (s_axi_araddr == OFF_MODCODE) ||
                   (s_axi_araddr == OFF_MODSTAT);
  wire [DATA_W-1:0] rd_word =
    (s_axi_araddr == OFF_CTRL)    ? ctrl_word :
    rd_stat_a                     ? stat_word :
    (s_axi_araddr == OFF_KEYDATA) ? key_word :
    (s_axi_araddr == OFF_MODCODE) ? mod_codes_r :
    (s_axi_araddr == OFF_MODSTAT) ? DATA_W'(mod_stat_r) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awready_r <= !aw_hold_nxt && !bvalid_nxt;
      wready_r  <= !w_hold_nxt && !bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_hs) waddr_r <= s_axi_awaddr;
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      // only control and modifier words are writable
      if (wr_do) bresp_r <= (wr_ctrl || wr_mod) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // read channel: answer one cycle after the address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_word;
        rresp_r <= mapped_rd ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // configuration registers, counts kept in range
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_r        <= 1'b0;
      rows_cfg_r  <= ROWS_MAX;
      cols_cfg_r  <= COLS_MAX;
      mod_codes_r <= {NUM_MODS{MOD_CODE_RST}};
    end else begin
      if (wr_ctrl) begin
        en_r       <= ctrl_new[CTRL_EN_BIT];
        rows_cfg_r <= ROWS_W'(clamp(
          COLS_W'(ctrl_new[CTRL_ROWS_LSB +: ROWS_W]),
          COLS_W'(ROWS_MAX)));
        cols_cfg_r <= clamp(ctrl_new[CTRL_COLS_LSB +: COLS_W],
                            COLS_MAX);
      end
      if (wr_mod) mod_codes_r <= mod_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: a set in the clearing cycle wins

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ghost_r    <= 1'b0;
      key_seen_r <= 1'b0;
      ovf_r      <= 1'b0;
    end else begin
      ghost_r    <= (ghost_r && !rd_stat) || (step && ghost_hit);
      key_seen_r <= (key_seen_r && !rd_stat) || (step && cur_key);
      ovf_r      <= (ovf_r && !rd_key) || (push && fifo_full);
    end
  end

  // key code buffer, kept until read
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) fifo_r[i] <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
    end else begin
      if (push_ok) begin
        fifo_r[wp_r] <= key_idx_r;
        wp_r <= wp_r + FIFO_AW'(1);
      end
      if (pop) rp_r <= rp_r + FIFO_AW'(1);
      if (push_ok && !pop) lvl_r <= lvl_r + LEVEL_W'(1);
      else if (pop && !push_ok) lvl_r <= lvl_r - LEVEL_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan step divider, runs only while the clock is requested

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r  <= '0;
      rows_prev_r <= '0;
    end else begin
      tick_cnt_r  <= (!clk_req_r || tick) ? '0 : tick_cnt_r + TICK_W'(1);
      rows_prev_r <= rows_f;
    end
  end

  // scan sequence
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= S_IDLE;
      row_r      <= '0;
      col_r      <= '0;
      key_idx_r  <= '0;
      row_hit_r  <= '0;
      key_pass_r <= 1'b0;
      mod_pass_r <= '0;
      mod_stat_r <= '0;
      clk_req_r  <= 1'b0;
      col_drv_r  <= {NUM_COLS{1'b1}};
    end else begin
      unique case (state_r)
        // all columns high, wait for a row to move
        S_IDLE: begin
          col_drv_r  <= {NUM_COLS{1'b1}};
          row_r      <= '0;
          col_r      <= '0;
          key_idx_r  <= '0;
          row_hit_r  <= '0;
          key_pass_r <= 1'b0;
          mod_pass_r <= '0;
          if (wake) begin
            state_r   <= S_SCAN;
            clk_req_r <= 1'b1;
            col_drv_r <= col_sel('0);
          end
        end
        // one matrix position per step
        S_SCAN: begin
          if (!en_r) begin
            state_r   <= S_IDLE;
            clk_req_r <= 1'b0;
            col_drv_r <= {NUM_COLS{1'b1}};
          end else if (tick) begin
            key_idx_r <= key_idx_r + CODE_W'(1);
            if (cur_key) key_pass_r <= 1'b1;
            if (cur_key) mod_pass_r <= mod_pass_r | mods;
            if (last_row && multi_hit(rows_act))
              row_hit_r <= row_hit_r | rows_act;
            if (!last_row) begin
              row_r <= row_r + ROW_IDX_W'(1);
            end else begin
              row_r <= '0;
              if (last_col) begin
                state_r   <= S_SCAN_END;
                col_drv_r <= '0;
              end else begin
                col_r     <= col_r + COLS_W'(1);
                col_drv_r <= col_sel(col_r + COLS_W'(1));
              end
            end
          end
        end
        // decide on another pass
        S_SCAN_END: begin
          mod_stat_r <= mod_pass_r;
          row_r      <= '0;
          col_r      <= '0;
          key_idx_r  <= '0;
          row_hit_r  <= '0;
          key_pass_r <= 1'b0;
          mod_pass_r <= '0;
          if (key_pass_r) begin
            state_r   <= S_SCAN;
            col_drv_r <= col_sel('0);
          end else begin
            state_r   <= S_IDLE;
            clk_req_r <= 1'b0;
            col_drv_r <= {NUM_COLS{1'b1}};
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign col_out       = col_drv_r;
  assign scan_clk_req  = clk_req_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule : keyboard_matrix_scanner

//--- tb/keyboard_matrix_scanner_chk.sv
// port checker for the key matrix scanner
// assumes binding into keyboard_matrix_scanner, one clock domain
`timescale 1ns/1ps
module keyboard_matrix_scanner_chk (
  input wire logic                                sys_clk,
  input wire logic                                rstn,
  input wire logic [kbd_scan_pkg::NUM_COLS-1:0]   col_out,
  input wire logic                                scan_clk_req,
  input wire logic                                s_axi_arvalid,
  input wire logic                                s_axi_arready,
  input wire logic                                s_axi_rvalid,
  input wire logic                                s_axi_rready,
  input wire logic [kbd_scan_pkg::DATA_W-1:0]     s_axi_rdata
);
  import kbd_scan_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [11:0] hold_r; // cycles the column drive has stood
  // restart the count whenever the column drive moves
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) hold_r <= 12'h000;
    else if ($changed(col_out)) hold_r <= 12'h000;
    else if (hold_r != 12'hFFF) hold_r <= hold_r + 12'h001;
  end
  ////////////////////////////////////////////////////////////////////
  a_idle_cols_high: assert property (
    !scan_clk_req |-> &col_out) else $error("idle columns not high");
  a_wake_col0: assert property (
    $rose(scan_clk_req) |-> col_out == 20'h00001)
    else $error("scan did not start on column zero");
  a_one_column: assert property (
    scan_clk_req && col_out != '0 |-> $onehot(col_out))
    else $error("more than one column driven");
  a_col_step: assert property (
    $onehot($past(col_out)) && $onehot(col_out) && $changed(col_out)
    |-> col_out == $past(col_out) << 1 && hold_r > 12'h5DC)
    else $error("column step wrong or early");
  a_end_next: assert property (
    scan_clk_req && col_out == '0 |=> (scan_clk_req && col_out == 20'h1)
    || (!scan_clk_req && &col_out)) else $error("bad scan end exit");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_read_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  c_scan_end: cover property (scan_clk_req && col_out == '0);
  c_sleep: cover property ($fell(scan_clk_req));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : keyboard_matrix_scanner_chk
bind keyboard_matrix_scanner keyboard_matrix_scanner_chk u_chk (.*);

//--- tb/key_matrix_model.sv
// passive key switch matrix between columns and rows
// assumes rows pulled low; key bit index is row*NUM_COLS+col
`timescale 1ns/1ps
module key_matrix_model (
  input wire logic [kbd_scan_pkg::NUM_COLS-1:0] col_out,
  input wire logic [159:0]                      key_down,
  output logic     [kbd_scan_pkg::NUM_ROWS-1:0] row_in
);
  import kbd_scan_pkg::*;
  // a row is high only through a pressed key on a driven column
  for (genvar r = 0; r < NUM_ROWS; r++) begin : g_row
    assign row_in[r] = |(key_down[r*NUM_COLS +: NUM_COLS] & col_out);
  end
endmodule : key_matrix_model

//--- tb/keyboard_matrix_scanner_tb.sv
// self-checking bench for the key matrix scanner
// assumes the key matrix model and the bound port checker
`timescale 1ns/1ps
module keyboard_matrix_scanner_tb;
  import kbd_scan_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;
                  logic [1:0] r;} row_t;
  logic [NUM_ROWS-1:0] row_in;
  logic [NUM_COLS-1:0] col_out;
  logic [159:0]        key_down = '0;
  logic sys_clk = 1'h0, rstn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic scan_clk_req, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs;
  int                n_mismatch, compares, cyc, n;
  row_t tbl [14] = '{'{0, OFF_CTRL, 32'h00140800, RESP_OKAY},
    '{0, OFF_MODCODE, 32'hFFFFFFFF, RESP_OKAY},
    '{0, OFF_STATUS, 32'h8, RESP_OKAY}, '{0, OFF_KEYDATA, 0, RESP_OKAY},
    '{0, 8'h14, 0, RESP_SLVERR}, '{1, OFF_STATUS, 0, RESP_SLVERR},
    '{1, OFF_CTRL, 32'h001F0F00, RESP_OKAY},
    '{0, OFF_CTRL, 32'h00140800, RESP_OKAY}, '{1, OFF_CTRL, 0, RESP_OKAY},
    '{0, OFF_CTRL, 32'h00010100, RESP_OKAY},
    '{1, OFF_MODCODE, 32'hFFFFFF01, RESP_OKAY},
    '{0, OFF_MODCODE, 32'hFFFFFF01, RESP_OKAY},
    '{1, OFF_CTRL, 32'h00030201, RESP_OKAY},
    '{0, OFF_CTRL, 32'h00030201, RESP_OKAY}};
  keyboard_matrix_scanner u_keyboard_matrix_scanner (.*);
  key_matrix_model u_key_matrix_model (.*);
  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] v, e);
    compares++;
    if (v !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  // register write: both halves offered, released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d  = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wait_col(input logic [NUM_COLS-1:0] v);
    for (int i = 0; i < 40000 && col_out !== v; i++) @(posedge sys_clk);
    chk("column drive", col_out, v);
  endtask : wait_col
  // empty the key buffer, counting entries and vetting each code
  task automatic drain(input logic lo);
    n = 0;
    repeat (17) begin
      rd(OFF_KEYDATA);
      if (d[8] === 1'h1) begin
        n++;
        chk("key code", lo ? d[7:0] < 8'h08 && d[7:0] != 8'h01
                           : d[7:0] == 8'h00, 1);
      end
    end
  endtask : drain
  task automatic complete_run();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'h1;
    foreach (tbl[i]) begin
      if (tbl[i].w) wr(tbl[i].a, tbl[i].d);
      else rd(tbl[i].a);
      if (!tbl[i].w) chk("read data", d, tbl[i].d);
      chk("response", rs, tbl[i].r);
    end
    $display("done: register table");
    key_down <= 160'h1;
    repeat (2) @(posedge sys_clk);
    key_down <= '0;
    repeat (20) @(posedge sys_clk);
    chk("glitch wake", scan_clk_req, 0);
    // two columns of two keys ghost; the row 1 key of column 0 is the modifier
    key_down <= 160'h700003;
    repeat (2) begin
      wait_col(20'h00001);
      wait_col(20'h00000);
    end
    rd(OFF_MODSTAT);
    chk("modifier seen", d, 32'h1);
    rd(OFF_STATUS);
    chk("ghost key busy", {d[5], d[2], d[0]}, 3'h7);
    key_down <= '0;
    wait_col(20'hFFFFF);
    chk("clock request", scan_clk_req, 0);
    drain(0);
    chk("codes kept", n, 2);
    $display("done: scan and ghost");
    // one column of eight keys overruns the buffer in three passes
    wr(OFF_CTRL, 32'h00010801);
    rd(OFF_STATUS);
    key_down <= 160'h0000100001000010000100001000010000100001;
    repeat (3) begin
      wait_col(20'h00001);
      wait_col(20'h00000);
    end
    key_down <= '0;
    wait_col(20'hFFFFF);
    rd(OFF_STATUS);
    chk("full status", d, 32'h00001016);
    drain(1);
    chk("buffer depth", n, 16);
    rd(OFF_STATUS);
    chk("drained status", d, 32'h8);
    $display("done: overflow");
    // disabling mid-scan drops straight back to idle
    key_down <= 160'h1;
    wait_col(20'h00001);
    wr(OFF_CTRL, 32'h00010800);
    @(posedge sys_clk);
    chk("disabled drive", col_out, 20'hFFFFF);
    chk("disabled request", scan_clk_req, 0);
    key_down <= '0;
    // a single byte lane reaches only its modifier code
    s_axi_wstrb <= 4'h1;
    wr(OFF_MODCODE, 32'h00000002);
    rd(OFF_MODCODE);
    chk("byte lane write", d, 32'hFFFFFF02);
    $display("done: disable and strobe");
    complete_run();
  end
endmodule : keyboard_matrix_scanner_tb
